// File: core/det_stepper.v
`timescale 1ns/1ns
// ==================================================
// walks a detector index over the enabled detectors
module det_stepper (
  input wire clk_i,
  input wire rst_i,
  input wire step_i,
  input wire [7:0] en_i,
  output reg [2:0] det_o
);
  // next enabled detector after cur, wrapping; stays if none
  function [2:0] next_en;
    input [2:0] cur;
    input [7:0] en;
    integer k;
    reg [2:0] c;
    reg hit;
    begin
      next_en = cur;
      hit = 1'b0;
      c = cur;
      for (k = 0; k < 8; k = k + 1) begin
        c = c + 3'h1;
        if (en[c] && !hit) begin
          next_en = c;
          hit = 1'b1;
        end
      end
    end
  endfunction

  // step on request only
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      det_o <= 3'h0;
    end else if (step_i) begin
      det_o <= next_en(det_o, en_i);
    end
  end
endmodule // det_stepper

// File: core/fault_code_display_latch.v
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/1ns
`include "fault_display_defs.vh"
// ==================================================
// fault identification, latching and two-digit display
module fault_code_display_latch #(
  parameter CYCLE_CYCLES = `CYCLE_CYCLES
) (
  input wire CORE_CLK_I,
  input wire RESET_I,
  // apb slave
  input wire PSEL_I,
  input wire PENABLE_I,
  input wire PWRITE_I,
  input wire [7:0] PADDR_I,
  input wire [31:0] PWDATA_I,
  output reg [31:0] PRDATA_O,
  output wire PREADY_O,
  output reg PSLVERR_O,
  // code 0 conditions
  input wire SUBTHRESH_UV_I,
  input wire COUNT_RATE_I,
  input wire INTEG_TROUBLE_I,
  input wire FIRE_DONE_I,
  // code 1
  input wire STANDBY_LOSS_I,
  // code 2
  input wire OPTICAL_INTEGRITY_CHECK_FAIL_I,
  // code 5, one bit per detector
  input wire [7:0] DET_LEAD_FAULT_I,
  // code 6
  input wire HV_SUPPLY_FAIL_I,
  // code 7
  input wire LV_SUPPLY_FAIL_I,
  input wire INTEG_MISSING_I,
  // code 8
  input wire RELAY_BOARD_FAIL_I,
  // front panel
  input wire BYPASS_I,
  input wire SELECT_I,
  input wire PANEL_RESET_I,
  // outputs
  output reg FAULT_RELAY_O,
  output reg FAULT_LAMP_O,
  output reg DISPLAY_ON_O,
  output reg [3:0] LEFT_DIGIT_O,
  output reg LEFT_BLANK_O,
  output reg [3:0] RIGHT_DIGIT_O,
  output reg RIGHT_BLANK_O,
  output wire IRQ_O
);
  // ==================================================
  // states
  localparam ST_IDLE = 4'h1; // no fault, dark
  localparam ST_LATCH = 4'h2; // first fault held
  localparam ST_BYPASS = 4'h4; // live display
  localparam ST_WAIT = 4'h8; // back in normal, not reset

  // ==================================================
  // helper functions

  // source index to display code
  function [3:0] code_of;
    input [2:0] idx;
    begin
      case (idx)
        `SRC_CODE0: code_of = 4'h0;
        `SRC_CODE1: code_of = 4'h1;
        `SRC_CODE2: code_of = 4'h2;
        `SRC_CODE5: code_of = 4'h5;
        `SRC_CODE6: code_of = 4'h6;
        `SRC_CODE7: code_of = 4'h7;
        default: code_of = 4'h8;
      endcase
    end
  endfunction

  // lowest faulted detector index
  function [2:0] first_det;
    input [7:0] v;
    integer k;
    begin
      first_det = 3'h0;
      for (k = 7; k >= 0; k = k - 1) begin
        if (v[k]) begin
          first_det = k[2:0];
        end
      end
    end
  endfunction

  // ==================================================
  // registers and state
  reg [3:0] state; // one-hot state
  reg [3:0] next_state;
  reg [7:0] det_en; // detectors enabled on supervision
  reg [20:0] ranks; // 3-bit rank per source
  reg [2:0] irq_stat; // sticky events
  reg [2:0] irq_mask; // event enables
  reg [2:0] lat_idx; // latched source
  reg [2:0] lat_det; // latched detector for code 5
  reg sel_prev; // select button history
  reg bypass_prev; // bypass history
  reg [31:0] div_cnt; // cycle dwell divider
  reg [3:0] next_right;
  reg [3:0] next_left;
  reg next_left_blank;
  reg next_right_blank;
  reg next_disp_on;
  reg [2:0] show_idx; // source being shown
  reg [2:0] show_det; // detector of code 5 shown
  wire [6:0] active; // live fault sources
  wire any_fault;
  wire [2:0] sel_idx;
  wire [2:0] cyc_det; // cycling detector
  wire [2:0] test_det; // manual test detector
  wire cyc_tick;
  wire sel_press;
  wire capture;
  wire wr;
  wire [2:0] ev; // events this cycle

  // ==================================================
  // fault gathering
  assign active[`SRC_CODE0] = SUBTHRESH_UV_I | COUNT_RATE_I | INTEG_TROUBLE_I
    | FIRE_DONE_I;
  assign active[`SRC_CODE1] = STANDBY_LOSS_I;
  assign active[`SRC_CODE2] = OPTICAL_INTEGRITY_CHECK_FAIL_I;
  assign active[`SRC_CODE5] = |DET_LEAD_FAULT_I;
  assign active[`SRC_CODE6] = HV_SUPPLY_FAIL_I;
  assign active[`SRC_CODE7] = LV_SUPPLY_FAIL_I | INTEG_MISSING_I;
  assign active[`SRC_CODE8] = RELAY_BOARD_FAIL_I;

  // same ranking for latch and bypass
  fault_rank_select u_rank (
    .active_i(active),
    .ranks_i(ranks),
    .any_o(any_fault),
    .idx_o(sel_idx)
  );

  // ==================================================
  // dwell divider for detector cycling
  // long dwell so the operator can read each number
  always @(posedge CORE_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      div_cnt <= 32'h0;
    end else if (div_cnt >= CYCLE_CYCLES - 1) begin
      div_cnt <= 32'h0;
    end else begin
      div_cnt <= div_cnt + 32'h1;
    end
  end
  assign cyc_tick = (div_cnt >= CYCLE_CYCLES - 1);

  det_stepper u_cycle (
    .clk_i(CORE_CLK_I),
    .rst_i(RESET_I),
    .step_i(cyc_tick),
    .en_i(det_en),
    .det_o(cyc_det)
  );

  det_stepper u_test (
    .clk_i(CORE_CLK_I),
    .rst_i(RESET_I),
    .step_i(sel_press),
    .en_i(det_en),
    .det_o(test_det)
  );

  // ==================================================
  // button edges
  always @(posedge CORE_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      sel_prev <= 1'b0;
      bypass_prev <= 1'b0;
    end else begin
      sel_prev <= SELECT_I;
      bypass_prev <= BYPASS_I;
    end
  end
  // held button counts once
  assign sel_press = SELECT_I & ~sel_prev & (state == ST_BYPASS);

  // ==================================================
  // mode state machine
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (BYPASS_I) begin
          next_state = ST_BYPASS;
        end else if (any_fault) begin
          next_state = ST_LATCH;
        end
      end
      ST_LATCH: begin
        if (BYPASS_I) begin
          next_state = ST_BYPASS;
        end
      end
      ST_BYPASS: begin
        if (!BYPASS_I) begin
          next_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (BYPASS_I) begin
          next_state = ST_BYPASS;
        end else if (any_fault) begin
          next_state = ST_LATCH;
        end else if (PANEL_RESET_I) begin
          // reset clears only with no fault
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // capture happens only on entry, so later faults never overwrite
  assign capture = (next_state == ST_LATCH) && (state != ST_LATCH);

  always @(posedge CORE_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      state <= ST_IDLE;
      lat_idx <= 3'h0;
      lat_det <= 3'h0;
    end else begin
      state <= next_state;
      if (capture) begin
        lat_idx <= sel_idx;
        lat_det <= first_det(DET_LEAD_FAULT_I);
      end
    end
  end

  // ==================================================
  // display selection
  always @* begin
    show_idx = lat_idx;
    show_det = lat_det;
    next_disp_on = 1'b1;
    next_right_blank = 1'b0;
    next_left_blank = 1'b0;
    next_right = 4'h0;
    next_left = 4'h0;
    if (state == ST_BYPASS) begin
      show_idx = sel_idx;
      show_det = first_det(DET_LEAD_FAULT_I);
    end
    next_right = code_of(show_idx);
    case (show_idx)
      `SRC_CODE5: next_left = {1'b0, show_det} + 4'h1;
      `SRC_CODE6: next_left = {1'b0, cyc_det} + 4'h1;
      `SRC_CODE2: next_left_blank = 1'b1;
      default: next_left = 4'h0;
    endcase
    case (state)
      ST_IDLE: begin
        next_disp_on = 1'b0;
        next_right_blank = 1'b1;
        next_left_blank = 1'b1;
        next_right = 4'h0;
        next_left = 4'h0;
      end
      ST_BYPASS: begin
        // empties to bypass code once clear
        if (!any_fault) begin
          next_right = `BYPASS_CODE;
          next_left = {1'b0, test_det} + 4'h1;
          next_left_blank = 1'b0;
        end
      end
      ST_WAIT: begin
        // not-reset indication
        next_right = `BYPASS_CODE;
        next_left = 4'h0;
        next_left_blank = 1'b0;
      end
      default: begin
        next_disp_on = 1'b1;
      end
    endcase
  end

  always @(posedge CORE_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      FAULT_RELAY_O <= 1'b0;
      FAULT_LAMP_O <= 1'b0;
      DISPLAY_ON_O <= 1'b0;
      LEFT_DIGIT_O <= 4'h0;
      LEFT_BLANK_O <= 1'b1;
      RIGHT_DIGIT_O <= 4'h0;
      RIGHT_BLANK_O <= 1'b1;
    end else begin
      // energized only while healthy and idle
      FAULT_RELAY_O <= (next_state == ST_IDLE) && !any_fault;
      FAULT_LAMP_O <= (state != ST_IDLE);
      DISPLAY_ON_O <= next_disp_on;
      LEFT_DIGIT_O <= next_left;
      LEFT_BLANK_O <= next_left_blank;
      RIGHT_DIGIT_O <= next_right;
      RIGHT_BLANK_O <= next_right_blank;
    end
  end

  // ==================================================
  // apb slave, zero wait, read data sampled in setup
  assign PREADY_O = 1'b1;
  assign wr = PSEL_I & PENABLE_I & PWRITE_I;

  always @(posedge CORE_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      PRDATA_O <= 32'h0;
      PSLVERR_O <= 1'b0;
    end else if (PSEL_I && !PENABLE_I) begin
      PSLVERR_O <= 1'b0;
      case (PADDR_I)
        `REG_CTRL: PRDATA_O <= {24'h0, det_en};
        `REG_PRIO: PRDATA_O <= {11'h0, ranks};
        `REG_STATUS: PRDATA_O <= {4'h0, state, 3'h0, LEFT_BLANK_O, LEFT_DIGIT_O,
          3'h0, RIGHT_BLANK_O, RIGHT_DIGIT_O, 1'b0, active};
        `REG_IRQ_STAT: PRDATA_O <= {29'h0, irq_stat};
        `REG_IRQ_MASK: PRDATA_O <= {29'h0, irq_mask};
        default: begin
          // unmapped: zero data and error
          PRDATA_O <= 32'h0;
          PSLVERR_O <= 1'b1;
        end
      endcase
    end
  end

  // writable registers
  always @(posedge CORE_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      det_en <= `CTRL_RESET;
      ranks <= `PRIO_RESET;
      irq_mask <= `MASK_RESET;
    end else if (wr) begin
      case (PADDR_I)
        `REG_CTRL: det_en <= PWDATA_I[7:0];
        `REG_PRIO: ranks <= PWDATA_I[20:0];
        `REG_IRQ_MASK: irq_mask <= PWDATA_I[2:0];
        default: det_en <= det_en;
      endcase
    end
  end

  // ==================================================
  // interrupt: latch, bypass entry, cleared by reset
  assign ev[0] = capture;
  assign ev[1] = BYPASS_I & ~bypass_prev;
  assign ev[2] = (state == ST_WAIT) && (next_state == ST_IDLE);

  // set wins over a same-cycle write-one clear
  always @(posedge CORE_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      irq_stat <= 3'h0;
    end else if (wr && PADDR_I == `REG_IRQ_STAT) begin
      irq_stat <= (irq_stat & ~PWDATA_I[2:0]) | ev;
    end else begin
      irq_stat <= irq_stat | ev;
    end
  end

  assign IRQ_O = |(irq_stat & irq_mask);
endmodule // fault_code_display_latch

// File: core/fault_rank_select.v
`timescale 1ns/1ns
`include "fault_display_defs.vh"
// ==================================================
// picks the active source with the lowest rank
module fault_rank_select (
  input wire [6:0] active_i,
  input wire [20:0] ranks_i,
  output reg any_o,
  output reg [2:0] idx_o
);
  integer i;
  reg [2:0] best_rank; // rank of current winner
  reg [2:0] r; // rank under test

  // ties go to the lower index so the choice never flickers
  always @* begin
    any_o = 1'b0;
    idx_o = 3'h0;
    best_rank = 3'h7;
    r = 3'h0;
    for (i = 0; i < `NUM_SRC; i = i + 1) begin
      r = ranks_i[i*3 +: 3];
      if (active_i[i] && (!any_o || r < best_rank)) begin
        any_o = 1'b1;
        idx_o = i[2:0];
        best_rank = r;
      end
    end
  end
endmodule // fault_rank_select

// File: shared/fault_display_defs.vh
// Behaviour
// - fault drops relay, lights lamp, shows display
// - right digit code, left digit detector number
// - non-detector fault left digit meaningless
// - first of sequential faults latched until bypass
// - simultaneous faults chosen by fixed priority (ranks here are writable through REG_PRIO)
// - bypass shows highest priority active fault
// - bypass falls to next active fault
// - code 0: uv, count, integrator, fire
// - code 1: standby dc power interrupted
// - code 2 blank left: integrity board
// - code 5: lead open, module missing, detector
// - code 6: high voltage supply or short
// - code 7: low supply or integrator board
// - code 8: relay drive board fault
// - bypass shows 8 and test detector
// - select press advances test detector
// - unattributed fault cycles enabled detectors
// - normal plus reset, no fault: blank
`ifndef FAULT_DISPLAY_DEFS_VH
`define FAULT_DISPLAY_DEFS_VH

// ==================================================
// register byte offsets
`define REG_CTRL 8'h00
`define REG_PRIO 8'h04
`define REG_STATUS 8'h08
`define REG_IRQ_STAT 8'h0c
`define REG_IRQ_MASK 8'h10

// ==================================================
// reset values
`define CTRL_RESET 8'hff
`define PRIO_RESET 21'h0fac68
`define MASK_RESET 3'h0

// ==================================================
// fault source indices and display codes
`define SRC_CODE0 3'h0
`define SRC_CODE1 3'h1
`define SRC_CODE2 3'h2
`define SRC_CODE5 3'h3
`define SRC_CODE6 3'h4
`define SRC_CODE7 3'h5
`define SRC_CODE8 3'h6
`define NUM_SRC 7
`define BYPASS_CODE 4'h8

// ==================================================
// status field positions
`define STAT_RIGHT_LSB 8
`define STAT_LEFT_LSB 16
`define STAT_STATE_LSB 24

// ==================================================
// timing: detector cycle dwell
`define CLK_KHZ 100000
`define CYCLE_MS 1000
`define CYCLE_CYCLES (`CYCLE_MS * `CLK_KHZ)

`endif

// File: verification/fault_code_display_latch_properties.sv
`timescale 1ns/1ns
// ==================================================
// port-level checks of the fault display
module fault_display_checker (
  input wire CORE_CLK_I,
  input wire RESET_I,
  input wire PSEL_I,
  input wire PENABLE_I,
  input wire [7:0] PADDR_I,
  input wire PREADY_O,
  input wire PSLVERR_O,
  input wire SUBTHRESH_UV_I,
  input wire COUNT_RATE_I,
  input wire INTEG_TROUBLE_I,
  input wire FIRE_DONE_I,
  input wire STANDBY_LOSS_I,
  input wire OPTICAL_INTEGRITY_CHECK_FAIL_I,
  input wire [7:0] DET_LEAD_FAULT_I,
  input wire HV_SUPPLY_FAIL_I,
  input wire LV_SUPPLY_FAIL_I,
  input wire INTEG_MISSING_I,
  input wire RELAY_BOARD_FAIL_I,
  input wire BYPASS_I,
  input wire FAULT_RELAY_O,
  input wire FAULT_LAMP_O,
  input wire DISPLAY_ON_O,
  input wire [3:0] LEFT_DIGIT_O,
  input wire LEFT_BLANK_O,
  input wire [3:0] RIGHT_DIGIT_O,
  input wire RIGHT_BLANK_O
);
  // any supervised condition at the inputs
  wire fault_any = SUBTHRESH_UV_I | COUNT_RATE_I | INTEG_TROUBLE_I | FIRE_DONE_I |
    STANDBY_LOSS_I | OPTICAL_INTEGRITY_CHECK_FAIL_I | (|DET_LEAD_FAULT_I) |
    HV_SUPPLY_FAIL_I | LV_SUPPLY_FAIL_I | INTEG_MISSING_I | RELAY_BOARD_FAIL_I;
  // decoded register offsets
  wire mapped = (PADDR_I == 8'h00) | (PADDR_I == 8'h04) | (PADDR_I == 8'h08) |
    (PADDR_I == 8'h0c) | (PADDR_I == 8'h10);
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (RESET_I);
  // ==================================================
  // assertions
  a_relay_drop: assert property (fault_any |=> !FAULT_RELAY_O)
    else $error("relay stayed energized on a fault");
  a_lamp_follow: assert property ($fell(FAULT_RELAY_O) |=> FAULT_LAMP_O && DISPLAY_ON_O)
    else $error("lamp or display missing after relay drop");
  a_apb_ready: assert property (PSEL_I |-> PREADY_O)
    else $error("ready low in a transfer");
  a_unmapped_err: assert property (PSEL_I && PENABLE_I && !mapped |-> PSLVERR_O)
    else $error("no error on unmapped address");
  a_mapped_ok: assert property (PSEL_I && PENABLE_I && mapped |-> !PSLVERR_O)
    else $error("error on mapped address");
  a_code2_blank: assert property (!RIGHT_BLANK_O && RIGHT_DIGIT_O == 4'h2 |-> LEFT_BLANK_O)
    else $error("left digit shown with code 2");
  // a new first fault may replace the not-reset 8 shown after bypass
  a_latch_hold: assert property ((!BYPASS_I && !RIGHT_BLANK_O) [*4] |->
    $stable(RIGHT_DIGIT_O) || $past(RIGHT_DIGIT_O) == 4'h8)
    else $error("latched code changed outside bypass");
  a_bypass_eight: assert property ((BYPASS_I && !fault_any) [*4] |->
    !RIGHT_BLANK_O && RIGHT_DIGIT_O == 4'h8 && FAULT_LAMP_O)
    else $error("bypass code not shown");
  a_code5_det: assert property (!RIGHT_BLANK_O && RIGHT_DIGIT_O == 4'h5 |->
    !LEFT_BLANK_O && LEFT_DIGIT_O >= 4'h1 && LEFT_DIGIT_O <= 4'h8)
    else $error("code 5 without detector number");
  a_idle_blank: assert property (FAULT_RELAY_O && $past(FAULT_RELAY_O) |->
    !FAULT_LAMP_O && RIGHT_BLANK_O && !DISPLAY_ON_O)
    else $error("display active while healthy");
  // main scenarios reached
  cover property (fault_any ##1 !FAULT_RELAY_O);
  cover property (BYPASS_I && RIGHT_DIGIT_O == 4'h5);
  cover property (PSLVERR_O);
endmodule // fault_display_checker

bind fault_code_display_latch fault_display_checker u_chk (
  .CORE_CLK_I, .RESET_I, .PSEL_I, .PENABLE_I, .PADDR_I, .PREADY_O, .PSLVERR_O,
  .SUBTHRESH_UV_I, .COUNT_RATE_I, .INTEG_TROUBLE_I, .FIRE_DONE_I, .STANDBY_LOSS_I,
  .OPTICAL_INTEGRITY_CHECK_FAIL_I, .DET_LEAD_FAULT_I, .HV_SUPPLY_FAIL_I,
  .LV_SUPPLY_FAIL_I, .INTEG_MISSING_I, .RELAY_BOARD_FAIL_I, .BYPASS_I,
  .FAULT_RELAY_O, .FAULT_LAMP_O, .DISPLAY_ON_O, .LEFT_DIGIT_O, .LEFT_BLANK_O,
  .RIGHT_DIGIT_O, .RIGHT_BLANK_O
);

// File: verification/fault_code_display_latch_tb.sv
`timescale 1ns/1ns
// ==================================================
// self-checking bench for the fault display block
module fault_code_display_latch_tb;
  reg core_clk, reset, psel, penable, pwrite, err;
  reg [7:0] paddr;
  reg [31:0] pwdata, rd;
  wire [31:0] prdata;
  wire pready, pslverr, relay, lamp, disp_on, lblank, rblank, irq, byp, sel, prst;
  wire [3:0] left, right;
  wire [9:0] flt;
  wire [7:0] lead;
  integer num_errors, check_count;
  // short dwell keeps the detector cycling visible
  fault_code_display_latch #(.CYCLE_CYCLES(4)) u_dut (
    .CORE_CLK_I(core_clk), .RESET_I(reset), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .SUBTHRESH_UV_I(flt[0]), .COUNT_RATE_I(flt[1]),
    .INTEG_TROUBLE_I(flt[2]), .FIRE_DONE_I(flt[3]), .STANDBY_LOSS_I(flt[4]),
    .OPTICAL_INTEGRITY_CHECK_FAIL_I(flt[5]), .DET_LEAD_FAULT_I(lead),
    .HV_SUPPLY_FAIL_I(flt[6]), .LV_SUPPLY_FAIL_I(flt[7]), .INTEG_MISSING_I(flt[8]),
    .RELAY_BOARD_FAIL_I(flt[9]), .BYPASS_I(byp), .SELECT_I(sel), .PANEL_RESET_I(prst),
    .FAULT_RELAY_O(relay), .FAULT_LAMP_O(lamp), .DISPLAY_ON_O(disp_on),
    .LEFT_DIGIT_O(left), .LEFT_BLANK_O(lblank), .RIGHT_DIGIT_O(right),
    .RIGHT_BLANK_O(rblank), .IRQ_O(irq));
  panel_loop_model u_model (.clk_i(core_clk), .flt_o(flt), .lead_o(lead),
    .bypass_o(byp), .select_o(sel), .reset_o(prst));
  // ==================================================
  // clock and common tasks
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task give_verdict;
    begin
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
    end
  endtask
  task chk(input [63:0] what, input [31:0] exp, input [31:0] got);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        $display("Error %0s expected %h seen %h", what, exp, got);
        num_errors = num_errors + 1;
      end
    end
  endtask
  // one apb transfer, request held until ready is seen
  task apb(input w, input [7:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      n = 0;
      @(posedge core_clk);
      while (pready !== 1'b1 && n < 16) begin
        n = n + 1;
        @(posedge core_clk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 16) begin
        num_errors = num_errors + 1;
        give_verdict;
      end
    end
  endtask
  // let registered outputs settle past the edge
  task wt(input integer n);
    begin
      repeat (n) @(posedge core_clk);
      #1;
    end
  endtask
  // right code, and left digit unless l is above 4'hc
  task dchk(input [3:0] r, input [3:0] l);
    begin
      chk("right", r, right);
      chk("rblank", 0, rblank);
      if (l < 4'hd) chk("left", l, left);
      if (l < 4'hd) chk("lblank", 0, lblank);
    end
  endtask
  // clear faults through bypass, then normal and panel reset
  task recover;
    begin
      u_model.set_byp(1'b1);
      u_model.set_f(18'h0);
      wt(3);
      u_model.set_byp(1'b0);
      wt(4);
      u_model.press(1'b1);
      wt(3);
      chk("relay", 1, relay);
    end
  endtask
  // ==================================================
  // scenarios
  task s_regs;
    begin
      apb(0, 8'h00, 0);
      chk("ctrl", 32'h0000_00ff, rd);
      apb(0, 8'h04, 0);
      chk("prio", 32'h000f_ac68, rd);
      apb(0, 8'h10, 0);
      chk("mask", 0, rd);
      apb(1, 8'h08, 32'hffff_ffff);
      chk("roerr", 0, err);
      apb(0, 8'h08, 0);
      chk("status", 32'h0110_1000, rd);
      apb(0, 8'h14, 0);
      chk("nomap", 1, err);
      chk("nodata", 0, rd);
    end
  endtask
  task s_latch;
    begin
      u_model.set_f(18'h00010);
      wt(3);
      chk("relay", 0, relay);
      chk("lamp", 1, lamp);
      dchk(4'h1, 4'h0);
      chk("irqmask", 0, irq);
      apb(1, 8'h10, 32'h7);
      wt(1);
      chk("irq", 1, irq);
      u_model.set_f(18'h00011);
      wt(3);
      dchk(4'h1, 4'h0);
      u_model.set_byp(1'b1);
      wt(3);
      dchk(4'h0, 4'hf);
      u_model.set_f(18'h00010);
      wt(3);
      dchk(4'h1, 4'hf);
      u_model.set_f(18'h0);
      wt(3);
      dchk(4'h8, 4'h1);
      u_model.press(1'b0);
      wt(1);
      dchk(4'h8, 4'h2);
      u_model.set_byp(1'b0);
      wt(4);
      dchk(4'h8, 4'h0);
      u_model.press(1'b1);
      wt(3);
      chk("rblank", 1, rblank);
      chk("lamp", 0, lamp);
      apb(1, 8'h0c, 32'h7);
      wt(1);
      chk("irqclr", 0, irq);
    end
  endtask
  task run_code(input [17:0] v, input [3:0] r, input [3:0] l);
    begin
      u_model.set_f(v);
      wt(3);
      chk("relay", 0, relay);
      chk("disp", 1, disp_on);
      dchk(r, l);
      if (l == 4'he) chk("lblank", 1, lblank);
      recover;
    end
  endtask
  task s_codes;
    begin
      run_code(18'h00001, 4'h0, 4'h0);
      run_code(18'h00002, 4'h0, 4'h0);
      run_code(18'h00004, 4'h0, 4'h0);
      run_code(18'h00008, 4'h0, 4'h0);
      run_code(18'h00020, 4'h2, 4'he);
      run_code(18'h0b000, 4'h5, 4'h3);
      run_code(18'h00040, 4'h6, 4'hf);
      run_code(18'h00080, 4'h7, 4'h0);
      run_code(18'h00100, 4'h7, 4'h0);
      run_code(18'h00200, 4'h8, 4'h0);
    end
  endtask
  // ranking, re-ranking and detector cycling
  task s_prio;
    begin
      run_code(18'h00050, 4'h6, 4'hf);
      apb(1, 8'h04, 32'h000f_fc40);
      apb(0, 8'h04, 0);
      chk("prio", 32'h000f_fc40, rd);
      u_model.set_f(18'h00050);
      wt(3);
      dchk(4'h1, 4'h0);
      u_model.set_byp(1'b1);
      wt(3);
      dchk(4'h1, 4'hf);
      recover;
      apb(1, 8'h04, 32'h000f_ac68);
      apb(1, 8'h00, 32'h4);
      // let one dwell tick land on the single enabled detector first
      wt(4);
      run_code(18'h00040, 4'h6, 4'h3);
      apb(1, 8'h00, 32'hff);
    end
  endtask
  // ==================================================
  // main sequence
  initial begin
    num_errors = 0;
    check_count = 0;
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (4) @(posedge core_clk);
    reset <= 1'b0;
    wt(1);
    s_regs;
    s_latch;
    s_codes;
    s_prio;
    give_verdict;
  end
endmodule // fault_code_display_latch_tb

// File: verification/panel_loop_model.sv
`timescale 1ns/1ns
// ==================================================
// operator panel and detector supervision loops
module panel_loop_model (
  input wire clk_i,
  output reg [9:0] flt_o,
  output reg [7:0] lead_o,
  output reg bypass_o,
  output reg select_o,
  output reg reset_o
);
  // all loops healthy, switch in normal, buttons up
  initial begin
    flt_o = 10'h000;
    lead_o = 8'h00;
    bypass_o = 1'b0;
    select_o = 1'b0;
    reset_o = 1'b0;
  end
  // fault conditions change just after an edge, as a level
  task set_f(input [17:0] v);
    begin
      @(posedge clk_i);
      flt_o <= v[9:0];
      lead_o <= v[17:10];
    end
  endtask
  // mode switch, a level that stays put
  task set_byp(input b);
    begin
      @(posedge clk_i);
      bypass_o <= b;
    end
  endtask
  task press(input rst);
    begin
      @(posedge clk_i);
      if (rst) begin
        reset_o <= 1'b1;
      end else begin
        select_o <= 1'b1;
      end
      repeat (3) @(posedge clk_i);
      reset_o <= 1'b0;
      select_o <= 1'b0;
      repeat (2) @(posedge clk_i);
    end
  endtask
endmodule // panel_loop_model
